/* omsg_config_bank.sv */
`timescale 1ns/10ps
// What this block does
// - Two-bit group select picks one of four paths
// - Groups A to F fan out to outputs
// - Second select register holds groups D, E, F
// - Stop bit stops output when source is register
// - Output stop is own bit OR global
// - Stop registers map outputs 1-8 and 9-10
// - Codes 0-3: input, inverted input, drive low/high
// - Codes 4-7: follow, inverted, two open-drain forms
// - Config registers hold two pin fields each
// - Pin level readable in every configuration
// - Follow-mode pin tracks pointed status bit
// - Bit select picks bit 0 to 7
// - Unimplemented pointed bit drives pin low
// - Pin status and interrupt enables not followable
// - Four pointer registers, index and bit select
// - Slave address fixed upper bits at reset
// - Slave address low bits from mode pins
// - Hard and soft reset keep slave address
// - Global stop bit sits in master register
// - Pin level unaffected by input inversion
module omsg_config_bank
  import omsg_pkg::*;
#(
  parameter logic [NUM_STATUS_BITS-1:0] STATUS_IMPL_MASK = '1,
  parameter logic [4:0] PLL1_IRQ_EN_INDEX = 5'h0A,
  parameter logic [4:0] PLL2_IRQ_EN_INDEX = 5'h0B
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Mode straps
  input wire logic interface_mode_pin_1,
  input wire logic interface_mode_pin_0,
  // Core status and stop sources
  input wire logic [NUM_STATUS_BITS-1:0] status_bits,
  input omsg_stop_src_type stop_source_select,
  // Pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out_q,
  output logic [NUM_PINS-1:0] gpio_oe_q,
  output logic [NUM_PINS-1:0] pin_level_q,
  output logic [NUM_PINS-1:0] pin_value_q,
  // Core controls
  output omsg_group_sel_type group_sel_q,
  output omsg_output_sel_type output_sel_q,
  output logic [NUM_OUTPUTS-1:0] output_stop_q,
  output logic hard_reset_q,
  output logic soft_reset_q,
  output logic [6:0] slave_address_q
);

  // Refused at elaboration: an enable index on the pin status row breaks the exclusion
  if (PLL1_IRQ_EN_INDEX == PIN_STATUS_INDEX
      || PLL2_IRQ_EN_INDEX == PIN_STATUS_INDEX) begin : g_bad_index
    $error("interrupt enable index collides with pin status");
  end

  function automatic logic [NUM_STATUS_BITS-1:0] follow_mask_of();
    logic [NUM_STATUS_BITS-1:0] m;
    m = STATUS_IMPL_MASK;
    for (int b = 0; b < 8; b++) begin
      m[{PIN_STATUS_INDEX, 3'(b)}] = 1'b0;
      m[{PLL1_IRQ_EN_INDEX, 3'(b)}] = 1'b0;
      m[{PLL2_IRQ_EN_INDEX, 3'(b)}] = 1'b0;
    end
    return m;
  endfunction

  // Output number (0 based) to its group
  function automatic int group_of(input int out);
    unique case (out)
      0, 1: return 0;
      2: return 1;
      3, 4: return 2;
      5, 6: return 3;
      7: return 4;
      default: return 5;
    endcase
  endfunction

  localparam logic [NUM_STATUS_BITS-1:0] FOLLOW_MASK = follow_mask_of();

  logic core_rst;
  logic wr_en;
  logic global_stop_q;
  logic [NUM_OUTPUTS-1:0] stop_bits_q;
  logic [NUM_PINS-1:0][3:0] pin_cfg_q;
  omsg_pointer_type [NUM_PINS-1:0] pointer_q;
  logic [1:0] mode_meta_q;
  logic [1:0] mode_sync_q;
  logic [NUM_PINS-1:0] pin_meta_q;
  logic [7:0] rd_d;

  assign core_rst = rst | hard_reset_q | soft_reset_q;
  assign wr_en = ce & reg_wr;

  // Straps and pins cross in from outside; never reset so they track during reset
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      mode_meta_q <= {interface_mode_pin_1, interface_mode_pin_0};
      mode_sync_q <= mode_meta_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      pin_meta_q <= gpio_in;
      pin_level_q <= pin_meta_q;
    end
  end

  // Master register: hard reset clears on the reset pin or a register write, never on core reset
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (rst) begin
        hard_reset_q <= 1'b0;
      end else if (reg_wr && reg_addr == MASTER_CFG_OFS) begin
        hard_reset_q <= reg_wdata[HARD_RESET_POS];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (rst || hard_reset_q) begin
        soft_reset_q <= 1'b0;
      end else if (reg_wr && reg_addr == MASTER_CFG_OFS) begin
        soft_reset_q <= reg_wdata[SOFT_RESET_POS];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        global_stop_q <= 1'b0;
      end else if (reg_wr && reg_addr == MASTER_CFG_OFS) begin
        global_stop_q <= reg_wdata[GLOBAL_STOP_POS];
      end
    end
  end

  // Group source selects
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        group_sel_q <= '0;
      end else if (reg_wr && reg_addr == SOURCE_SEL_1_OFS) begin
        group_sel_q[2:0] <= reg_wdata[5:0];
      end else if (reg_wr && reg_addr == SOURCE_SEL_2_OFS) begin
        group_sel_q[5:3] <= reg_wdata[5:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        output_sel_q <= '0;
      end else begin
        for (int i = 0; i < NUM_OUTPUTS; i++) begin
          output_sel_q[i] <= group_sel_q[group_of(i)];
        end
      end
    end
  end

  // Stop bits
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        stop_bits_q <= '0;
      end else if (reg_wr && reg_addr == STOP_BITS_1_OFS) begin
        stop_bits_q[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == STOP_BITS_2_OFS) begin
        stop_bits_q[9:8] <= reg_wdata[1:0];
      end
    end
  end

  // Only outputs whose stop source is the register path honour these bits
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        output_stop_q <= '0;
      end else begin
        for (int i = 0; i < NUM_OUTPUTS; i++) begin
          output_stop_q[i] <= (stop_source_select[i] == STOP_SRC_REGISTER)
                              && (stop_bits_q[i] || global_stop_q);
        end
      end
    end
  end

  // Pin configuration and pointers
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        pin_cfg_q <= '0;
      end else if (reg_wr && reg_addr == PIN_CONFIG_1_OFS) begin
        pin_cfg_q[1:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == PIN_CONFIG_2_OFS) begin
        pin_cfg_q[3:2] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        pointer_q <= '0;
      end else if (reg_wr) begin
        for (int p = 0; p < NUM_PINS; p++) begin
          if (reg_addr == PIN0_POINTER_OFS + 8'(p)) begin
            pointer_q[p] <= reg_wdata;
          end
        end
      end
    end
  end

  // Slave address survives hard and soft reset
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (rst) begin
        slave_address_q <= {SLAVE_ADDR_FIXED, mode_sync_q};
      end else if (reg_wr && reg_addr == SLAVE_ADDRESS_OFS) begin
        slave_address_q <= reg_wdata[6:0];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_d = REG_RESET_VALUE;
    unique case (reg_addr)
      MASTER_CFG_OFS: begin
        rd_d[SOFT_RESET_POS] = soft_reset_q;
        rd_d[HARD_RESET_POS] = hard_reset_q;
        rd_d[GLOBAL_STOP_POS] = global_stop_q;
      end
      SOURCE_SEL_1_OFS: rd_d = {2'b00, group_sel_q[2:0]};
      SOURCE_SEL_2_OFS: rd_d = {2'b00, group_sel_q[5:3]};
      STOP_BITS_1_OFS: rd_d = stop_bits_q[7:0];
      STOP_BITS_2_OFS: rd_d = {6'h00, stop_bits_q[9:8]};
      PIN_CONFIG_1_OFS: rd_d = pin_cfg_q[1:0];
      PIN_CONFIG_2_OFS: rd_d = pin_cfg_q[3:2];
      PIN0_POINTER_OFS: rd_d = pointer_q[0];
      PIN1_POINTER_OFS: rd_d = pointer_q[1];
      PIN2_POINTER_OFS: rd_d = pointer_q[2];
      PIN3_POINTER_OFS: rd_d = pointer_q[3];
      SLAVE_ADDRESS_OFS: rd_d = {1'b0, slave_address_q};
      PIN_STATUS_OFS: rd_d = {4'h0, pin_level_q};
      default: rd_d = REG_RESET_VALUE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (rst) begin
        reg_rdata_q <= REG_RESET_VALUE;
      end else if (reg_rd) begin
        reg_rdata_q <= rd_d;
      end
    end
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    omsg_pin_ctrl u_pin (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .core_rst(core_rst),
      .cfg(pin_cfg_q[p]),
      .ptr(pointer_q[p]),
      .status_bits(status_bits),
      .follow_mask(FOLLOW_MASK),
      .pin_level(pin_level_q[p]),
      .pin_out_q(gpio_out_q[p]),
      .pin_oe_q(gpio_oe_q[p]),
      .pin_value_q(pin_value_q[p])
    );
  end

  sequence s_stop_written;
    wr_en && !core_rst && reg_addr == STOP_BITS_1_OFS;
  endsequence

  sequence s_stop_settled;
    ce [*2];
  endsequence

  a_stop_reaches_out: assert property (@(posedge sys_clk) disable iff (rst)
    s_stop_written ##1 (!core_rst && stop_source_select[0] == STOP_SRC_REGISTER
    && !global_stop_q) ##0 s_stop_settled
    |-> output_stop_q[0] == $past(stop_bits_q[0]))
    else $error("output 1 stop does not follow its bit");

  a_global_stop_or: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !core_rst && global_stop_q && stop_source_select[9] == STOP_SRC_REGISTER
    |=> output_stop_q[9])
    else $error("global stop ignored");

  a_stop_needs_src: assert property (@(posedge sys_clk) disable iff (rst)
    ce && stop_source_select[3] != STOP_SRC_REGISTER |=> !output_stop_q[3])
    else $error("stop applied with foreign source");

  // Three reset edges first, so the strap synchroniser holds real levels
  a_addr_reset_load: assert property (@(posedge sys_clk)
    (rst && ce) [*3] |=> slave_address_q == {SLAVE_ADDR_FIXED, $past(mode_sync_q)})
    else $error("slave address reset value wrong");

  a_addr_keeps_hard: assert property (@(posedge sys_clk) disable iff (rst)
    ce && (hard_reset_q || soft_reset_q) && !(reg_wr && reg_addr == SLAVE_ADDRESS_OFS)
    |=> $stable(slave_address_q))
    else $error("slave address moved under core reset");

  a_core_rst_clears: assert property (@(posedge sys_clk) disable iff (rst)
    ce && hard_reset_q |=> group_sel_q == '0 && pin_cfg_q == '0 && !soft_reset_q)
    else $error("hard reset left state behind");

  a_group_map: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !core_rst ##1 ce |-> output_sel_q[7] == $past(group_sel_q[4])
    && output_sel_q[8] == $past(group_sel_q[5]) && output_sel_q[2] == $past(group_sel_q[1]))
    else $error("output to group mapping wrong");

  a_read_addr_top: assert property (@(posedge sys_clk) disable iff (rst)
    ce && reg_rd && reg_addr == SLAVE_ADDRESS_OFS |=> reg_rdata_q[7] == 1'b0
    && reg_rdata_q[6:0] == $past(slave_address_q))
    else $error("slave address readback wrong");

  a_read_unmapped: assert property (@(posedge sys_clk) disable iff (rst)
    ce && reg_rd && reg_addr == SOURCE_SEL_2_OFS |=> reg_rdata_q[7:6] == 2'b00)
    else $error("unused select bits read nonzero");

endmodule

/* omsg_pkg.sv */
package omsg_pkg;

  localparam int NUM_GROUPS = 6;
  localparam int NUM_OUTPUTS = 10;
  localparam int NUM_PINS = 4;
  localparam int NUM_STATUS_BITS = 256;

  // Register offsets
  localparam logic [7:0] MASTER_CFG_OFS = 8'h01;
  localparam logic [7:0] SOURCE_SEL_1_OFS = 8'h07;
  localparam logic [7:0] SOURCE_SEL_2_OFS = 8'h08;
  localparam logic [7:0] STOP_BITS_1_OFS = 8'h09;
  localparam logic [7:0] STOP_BITS_2_OFS = 8'h0A;
  localparam logic [7:0] PIN_CONFIG_1_OFS = 8'h0B;
  localparam logic [7:0] PIN_CONFIG_2_OFS = 8'h0C;
  localparam logic [7:0] PIN0_POINTER_OFS = 8'h0D;
  localparam logic [7:0] PIN1_POINTER_OFS = 8'h0E;
  localparam logic [7:0] PIN2_POINTER_OFS = 8'h0F;
  localparam logic [7:0] PIN3_POINTER_OFS = 8'h10;
  localparam logic [7:0] SLAVE_ADDRESS_OFS = 8'h11;
  localparam logic [7:0] PIN_STATUS_OFS = 8'h41;

  // Field positions and values
  localparam int SOFT_RESET_POS = 7;
  localparam int HARD_RESET_POS = 6;
  localparam int GLOBAL_STOP_POS = 5;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h1D;
  localparam logic [3:0] STOP_SRC_REGISTER = 4'h1;
  localparam logic [7:0] STATUS_BASE = 8'h40;
  localparam logic [4:0] PIN_STATUS_INDEX = 5'h01;

  typedef enum logic [2:0] {
    PIN_INPUT, PIN_INPUT_INV, PIN_DRIVE_LOW, PIN_DRIVE_HIGH,
    PIN_FOLLOW, PIN_FOLLOW_INV, PIN_FOLLOW_LOW_ON_0, PIN_FOLLOW_LOW_ON_1
  } omsg_pin_mode_type;

  typedef struct packed {
    logic [4:0] reg_index;
    logic [2:0] bit_sel;
  } omsg_pointer_type;

  typedef logic [NUM_GROUPS-1:0][1:0] omsg_group_sel_type;
  typedef logic [NUM_OUTPUTS-1:0][3:0] omsg_stop_src_type;
  typedef logic [NUM_OUTPUTS-1:0][1:0] omsg_output_sel_type;

  function automatic omsg_pin_mode_type omsg_decode_mode(input logic [3:0] cfg);
    unique case (cfg)
      4'h0: return PIN_INPUT;
      4'h1: return PIN_INPUT_INV;
      4'h2: return PIN_DRIVE_LOW;
      4'h3: return PIN_DRIVE_HIGH;
      4'h4: return PIN_FOLLOW;
      4'h5: return PIN_FOLLOW_INV;
      4'h6: return PIN_FOLLOW_LOW_ON_0;
      4'h7: return PIN_FOLLOW_LOW_ON_1;
      default: return PIN_INPUT;
    endcase
  endfunction

  function automatic logic [7:0] omsg_status_index(input omsg_pointer_type ptr);
    return {ptr.reg_index, ptr.bit_sel};
  endfunction

endpackage

/* omsg_pin_ctrl.sv */
`timescale 1ns/10ps
module omsg_pin_ctrl
  import omsg_pkg::*;
(
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic core_rst,
  // Settings
  input wire logic [3:0] cfg,
  input omsg_pointer_type ptr,
  input wire logic [NUM_STATUS_BITS-1:0] status_bits,
  input wire logic [NUM_STATUS_BITS-1:0] follow_mask,
  // Pin
  input wire logic pin_level,
  output logic pin_out_q,
  output logic pin_oe_q,
  output logic pin_value_q
);

  omsg_pin_mode_type mode;
  logic [7:0] idx;
  logic sel_ok;
  logic sel_bit;

  always_comb begin
    mode = omsg_decode_mode(cfg);
    idx = omsg_status_index(ptr);
    sel_ok = follow_mask[idx];
    sel_bit = status_bits[idx];
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        pin_out_q <= 1'b0;
        pin_oe_q <= 1'b0;
      end else if (mode inside {PIN_FOLLOW, PIN_FOLLOW_INV, PIN_FOLLOW_LOW_ON_0,
                                PIN_FOLLOW_LOW_ON_1} && !sel_ok) begin
        pin_out_q <= 1'b0;
        pin_oe_q <= 1'b1;
      end else begin
        unique case (mode)
          PIN_INPUT, PIN_INPUT_INV: begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
          end
          PIN_DRIVE_LOW: begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b1;
          end
          PIN_DRIVE_HIGH: begin
            pin_out_q <= 1'b1;
            pin_oe_q <= 1'b1;
          end
          PIN_FOLLOW: begin
            pin_out_q <= sel_bit;
            pin_oe_q <= 1'b1;
          end
          PIN_FOLLOW_INV: begin
            pin_out_q <= ~sel_bit;
            pin_oe_q <= 1'b1;
          end
          PIN_FOLLOW_LOW_ON_0: begin
            pin_out_q <= 1'b0;
            pin_oe_q <= ~sel_bit;
          end
          PIN_FOLLOW_LOW_ON_1: begin
            pin_out_q <= 1'b0;
            pin_oe_q <= sel_bit;
          end
        endcase
      end
    end
  end

  // Inversion only affects the value handed to the core
  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (core_rst) begin
        pin_value_q <= 1'b0;
      end else begin
        pin_value_q <= pin_level ^ (mode == PIN_INPUT_INV);
      end
    end
  end

  a_open_drain_low: assert property (@(posedge sys_clk) disable iff (rst)
    pin_oe_q && $past(mode) inside {PIN_FOLLOW_LOW_ON_0, PIN_FOLLOW_LOW_ON_1}
    && $past(ce) |-> !pin_out_q)
    else $error("open drain follow drove high");

  a_bad_pointer_low: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !core_rst && !sel_ok && mode inside {PIN_FOLLOW, PIN_FOLLOW_INV,
                                               PIN_FOLLOW_LOW_ON_0, PIN_FOLLOW_LOW_ON_1}
    |=> pin_oe_q && !pin_out_q)
    else $error("invalid status pointer not driven low");

  a_input_floats: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !core_rst && cfg[3] |=> !pin_oe_q)
    else $error("unused code drove the pin");

endmodule

/* omsg_tb.sv */
`timescale 1ns/10ps
module testbench
  import omsg_pkg::*;
;
  // Status bit 0x30 left unimplemented to reach the invalid-pointer path
  localparam logic [NUM_STATUS_BITS-1:0] IMPL = ~(256'h1 << 8'h30);

  logic sys_clk;
  logic rst;
  logic ce;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic mode1;
  logic mode0;
  logic [NUM_STATUS_BITS-1:0] status_bits;
  omsg_stop_src_type stop_src;
  wire [NUM_PINS-1:0] gpio_in;
  logic [NUM_PINS-1:0] ext_lvl;
  logic [NUM_PINS-1:0] gpio_out_q;
  logic [NUM_PINS-1:0] gpio_oe_q;
  logic [NUM_PINS-1:0] pin_level_q;
  logic [NUM_PINS-1:0] pin_value_q;
  omsg_group_sel_type group_sel_q;
  omsg_output_sel_type output_sel_q;
  logic [NUM_OUTPUTS-1:0] output_stop_q;
  logic hard_reset_q;
  logic soft_reset_q;
  logic [6:0] slave_address_q;
  omsg_group_sel_type gs;
  logic [2:0] sb;
  int grp [NUM_OUTPUTS] = '{0, 0, 1, 2, 2, 3, 3, 4, 5, 5};
  logic [7:0] bad [4] = '{8'h08, {5'h0A, 3'h2}, {5'h0B, 3'h1}, 8'h30};
  int n_errors;
  int checks_done;

  // Pin wire: design drive wins, else the external pull level
  assign gpio_in = (gpio_oe_q & gpio_out_q) | (~gpio_oe_q & ext_lvl);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  omsg_config_bank #(
    .STATUS_IMPL_MASK(IMPL),
    .PLL1_IRQ_EN_INDEX(5'h0A),
    .PLL2_IRQ_EN_INDEX(5'h0B)
  ) i_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q),
    .interface_mode_pin_1(mode1),
    .interface_mode_pin_0(mode0),
    .status_bits(status_bits),
    .stop_source_select(stop_src),
    .gpio_in(gpio_in),
    .gpio_out_q(gpio_out_q),
    .gpio_oe_q(gpio_oe_q),
    .pin_level_q(pin_level_q),
    .pin_value_q(pin_value_q),
    .group_sel_q(group_sel_q),
    .output_sel_q(output_sel_q),
    .output_stop_q(output_stop_q),
    .hard_reset_q(hard_reset_q),
    .soft_reset_q(soft_reset_q),
    .slave_address_q(slave_address_q)
  );

  task automatic test_done;
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_q}, {8'h00, e});
  endtask

  // Expected {drive enable, driven value} for a config code and status bit
  function automatic logic [1:0] pin_exp(input int c, input logic s);
    case (c)
      2: return 2'b10;
      3: return 2'b11;
      4: return {1'b1, s};
      5: return {1'b1, ~s};
      6: return {~s, 1'b0};
      7: return {s, 1'b0};
      default: return 2'b00;
    endcase
  endfunction

  initial begin
    n_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    mode1 = 1'b1;
    mode0 = 1'b0;
    status_bits = '0;
    ext_lvl = 4'h0;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      stop_src[i] = (i == 3) ? 4'h0 : STOP_SRC_REGISTER;
    end
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    idle(1);
    chk(16'(slave_address_q), 16'h0076);
    rd(SLAVE_ADDRESS_OFS, 8'h76);
    for (int a = 7; a <= 16; a++) begin
      rd(8'(a), 8'h00);
    end
    rd(8'h20, 8'h00);
    // Rotate codes so every group sees all four selections
    for (int k = 0; k < 4; k++) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        gs[g] = 2'((g + k) % 4);
      end
      wr(SOURCE_SEL_1_OFS, {2'b00, gs[2], gs[1], gs[0]});
      wr(SOURCE_SEL_2_OFS, {2'b00, gs[5], gs[4], gs[3]});
      idle(2);
      chk(16'(group_sel_q), 16'(gs));
      for (int o = 0; o < NUM_OUTPUTS; o++) begin
        chk(16'(output_sel_q[o]), 16'(gs[grp[o]]));
      end
    end
    wr(SOURCE_SEL_2_OFS, 8'hFF);
    rd(SOURCE_SEL_2_OFS, 8'h3F);
    // Output 4 takes its stop from elsewhere, so its bit must not act
    wr(STOP_BITS_1_OFS, 8'hAD);
    wr(STOP_BITS_2_OFS, 8'hFF);
    idle(2);
    chk(16'(output_stop_q), 16'h03A5);
    rd(STOP_BITS_1_OFS, 8'hAD);
    rd(STOP_BITS_2_OFS, 8'h03);
    wr(STOP_BITS_1_OFS, 8'h00);
    wr(STOP_BITS_2_OFS, 8'h00);
    wr(MASTER_CFG_OFS, 8'h20);
    idle(2);
    chk(16'(output_stop_q), 16'h03F7);
    rd(MASTER_CFG_OFS, 8'h20);
    wr(MASTER_CFG_OFS, 8'h00);
    for (int p = 0; p < NUM_PINS; p++) begin
      sb = 3'((p * 7) % 8);
      wr(PIN0_POINTER_OFS + 8'(p), {5'h02, sb});
      rd(PIN0_POINTER_OFS + 8'(p), {5'h02, sb});
      for (int c = 0; c < 16; c++) begin
        wr(PIN_CONFIG_1_OFS + 8'(p / 2), 8'(c << (4 * (p % 2))));
        for (int s = 0; s < 2; s++) begin
          @(posedge sys_clk);
          status_bits[16 + sb] <= s[0];
          idle(3);
          // on the next line
          chk(16'({gpio_oe_q[p], gpio_oe_q[p] & gpio_out_q[p]}), 16'(pin_exp(c, s[0])));
        end
      end
    end
    // All ones makes a wrongly followed bit show as high
    @(posedge sys_clk);
    status_bits <= '1;
    wr(PIN_CONFIG_1_OFS, 8'h04);
    foreach (bad[i]) begin
      wr(PIN0_POINTER_OFS, bad[i]);
      idle(3);
      chk(16'({gpio_oe_q[0], gpio_out_q[0]}), 16'h0002);
    end
    wr(PIN0_POINTER_OFS, 8'h10);
    idle(3);
    chk(16'({gpio_oe_q[0], gpio_out_q[0]}), 16'h0003);
    // Open-drain follow of a high bit floats, but a bad pointer drives low
    wr(PIN_CONFIG_1_OFS, 8'h06);
    idle(3);
    chk(16'({gpio_oe_q[0], gpio_out_q[0]}), 16'h0000);
    wr(PIN0_POINTER_OFS, 8'h30);
    idle(3);
    chk(16'({gpio_oe_q[0], gpio_out_q[0]}), 16'h0002);
    wr(PIN_CONFIG_1_OFS, 8'h11);
    wr(PIN_CONFIG_2_OFS, 8'h11);
    ext_lvl <= 4'hA;
    idle(4);
    chk(16'(pin_level_q), 16'h000A);
    chk(16'(pin_value_q), 16'h0005);
    rd(PIN_STATUS_OFS, 8'h0A);
    wr(PIN_CONFIG_1_OFS, 8'h32);
    ext_lvl <= 4'h5;
    idle(4);
    rd(PIN_STATUS_OFS, 8'h06);
    wr(SLAVE_ADDRESS_OFS, 8'hFF);
    rd(SLAVE_ADDRESS_OFS, 8'h7F);
    @(posedge sys_clk);
    mode1 <= 1'b0;
    mode0 <= 1'b1;
    wr(MASTER_CFG_OFS, 8'h40);
    idle(3);
    chk(16'(slave_address_q), 16'h007F);
    chk(16'({hard_reset_q, soft_reset_q}), 16'h0002);
    chk(16'(group_sel_q), 16'h0000);
    rd(MASTER_CFG_OFS, 8'h40);
    wr(MASTER_CFG_OFS, 8'h00);
    wr(MASTER_CFG_OFS, 8'h80);
    idle(3);
    chk(16'({hard_reset_q, soft_reset_q}), 16'h0001);
    rd(SLAVE_ADDRESS_OFS, 8'h7F);
    wr(MASTER_CFG_OFS, 8'h00);
    idle(1);
    chk(16'({hard_reset_q, soft_reset_q}), 16'h0000);
    // A write while the enable is low must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(STOP_BITS_1_OFS, 8'hFF);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(STOP_BITS_1_OFS, 8'h00);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    idle(1);
    rd(SLAVE_ADDRESS_OFS, 8'h75);
    test_done();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
endmodule
